// ==== fan_enh_consts.vh ====
`ifndef FAN_ENH_CONSTS_VH
`define FAN_ENH_CONSTS_VH

// Register addresses
`define ADDR_ENH_CFG      8'h45
`define ADDR_PWM_CFG      8'h4a
`define ADDR_PWM_FREQ     8'h4d
`define ADDR_DUTY         8'h4c

// Reset values
`define RST_ENH_CFG       8'h00
`define RST_PWM_CFG       8'h20
`define RST_PWM_FREQ      5'h17
`define RST_DUTY          8'h00

// Enhanced configuration fields
`define ENH_FILT_BIT      6
`define ENH_TABLE_TEMP_RES_EXT_BIT      5
`define ENH_HRES_BIT      4
`define ENH_USF_BIT       3
`define ENH_RR_HI         2
`define ENH_RR_LO         1
`define ENH_SMOOTH_BIT    0
`define ENH_RW_MASK       8'h7f

// PWM configuration fields
`define PWM_PGM_BIT       5
`define PWM_POL_BIT       4
`define PWM_CLK_BIT       3

// Frequency code for 22.5 kHz with the 360 kHz master clock
`define FREQ_22K5_CODE    5'h08

// Ramp step times in microseconds
`define RAMP_T0_US        23000
`define RAMP_T1_US        46000
`define RAMP_T2_US        91000
`define RAMP_T3_US        182000
`define CLK_MHZ           100

`endif

// ==== fan_ramp_timer.v ====
`timescale 1ns/1ps
`include "fan_enh_consts.vh"
// ----------------------------------------
// Ramp step tick generator
// ----------------------------------------
module fan_ramp_timer #(
    parameter integer STEP0 = `RAMP_T0_US * `CLK_MHZ,
    parameter integer STEP1 = `RAMP_T1_US * `CLK_MHZ,
    parameter integer STEP2 = `RAMP_T2_US * `CLK_MHZ,
    parameter integer STEP3 = `RAMP_T3_US * `CLK_MHZ
) (
    input  wire       i_clk_sys,
    input  wire       i_nrst,
    input  wire       i_run,
    input  wire [1:0] i_rate,
    output wire       o_tick
);
    reg  [24:0] cnt_q;
    reg  [24:0] lim;

    always @* begin
        case (i_rate)
            2'b00:   lim = STEP0[24:0];
            2'b01:   lim = STEP1[24:0];
            2'b10:   lim = STEP2[24:0];
            default: lim = STEP3[24:0];
        endcase
    end

    assign o_tick = i_run && (cnt_q >= lim - 25'd1);

    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= 25'd0;
        end else if (!i_run || o_tick) begin
            cnt_q <= 25'd0;
        end else begin
            cnt_q <= cnt_q + 25'd1;
        end
    end
endmodule // fan_ramp_timer

// ==== fan_enh_cfg.v ====
`timescale 1ns/1ps
`include "fan_enh_consts.vh"

module fan_enh_cfg (
    input  wire       i_clk_sys,
    input  wire       i_nrst,
    // Register port from the serial interface decoder
    input  wire       i_reg_wr,
    input  wire [7:0] i_reg_addr,
    input  wire [7:0] i_reg_wdata,
    output reg  [7:0] o_reg_rdata,
    // Temperature path
    input  wire [7:0] i_temp_lsb_raw,
    input  wire       i_filter_active,
    output wire [7:0] o_temp_lsb,
    // Duty sources
    input  wire [7:0] i_lut_duty,
    input  wire       i_spinup,
    input  wire       i_crit_event,
    input  wire [7:0] i_crit_duty,
    input  wire [7:0] i_spin_duty,
    // Settings to the rest of the fan logic
    output wire       o_table_temp_res_ext,
    output wire       o_setpoint_unsigned_fmt,
    output wire       o_duty_high_res_active,
    output wire       o_master_clock_sel,
    output wire       o_output_polarity,
    output wire       o_fan_program_en,
    output reg  [7:0] o_duty
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg  [7:0] enh_q;
    reg  [7:0] pwm_cfg_q;
    reg  [4:0] freq_q;
    reg  [7:0] duty_q;
    reg  [7:0] duty_d;

    wire       prog_en   = pwm_cfg_q[`PWM_PGM_BIT];
    // 22.5 kHz needs the 360 kHz master clock and the matching divider
    wire       is_22k5   = !pwm_cfg_q[`PWM_CLK_BIT] &&
                           (freq_q == `FREQ_22K5_CODE);
    wire       smooth_en = enh_q[`ENH_SMOOTH_BIT];
    wire       hres      = enh_q[`ENH_HRES_BIT] && is_22k5;
    wire       wr_enh    = i_reg_wr && (i_reg_addr == `ADDR_ENH_CFG);
    wire       wr_duty   = i_reg_wr && (i_reg_addr == `ADDR_DUTY);
    wire [7:0] duty_max  = hres ? 8'hff : 8'h3f;
    wire [7:0] lut_tgt;
    wire       tick;

    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            enh_q     <= `RST_ENH_CFG;
            pwm_cfg_q <= `RST_PWM_CFG;
            freq_q    <= `RST_PWM_FREQ;
        end else begin
            if (wr_enh) begin
                if (prog_en) begin
                    enh_q <= i_reg_wdata & `ENH_RW_MASK;
                end else begin
                    enh_q <= {1'b0, i_reg_wdata[6:3], enh_q[2:0]};
                end
            end
            if (i_reg_wr && i_reg_addr == `ADDR_PWM_CFG) begin
                pwm_cfg_q <= {2'b00, i_reg_wdata[5:0]};
            end
            if (i_reg_wr && i_reg_addr == `ADDR_PWM_FREQ) begin
                freq_q <= i_reg_wdata[4:0];
            end
        end
    end

    // ----------------------------------------
    // Read-back and field outputs
    // ----------------------------------------
    // Top bit reads zero except at the duty register (0x4c)
    always @* begin
        if (i_reg_addr == `ADDR_ENH_CFG) begin
            o_reg_rdata = {1'b0, enh_q[6:0]};
        end else if (i_reg_addr == `ADDR_PWM_CFG) begin
            o_reg_rdata = pwm_cfg_q;
        end else if (i_reg_addr == `ADDR_PWM_FREQ) begin
            o_reg_rdata = {3'b000, freq_q};
        end else if (i_reg_addr == `ADDR_DUTY) begin
            o_reg_rdata = duty_q;
        end else begin
            o_reg_rdata = 8'h00;
        end
    end

    assign o_temp_lsb = (enh_q[`ENH_FILT_BIT] && i_filter_active) ?
                        i_temp_lsb_raw :
                        {i_temp_lsb_raw[7:5], 2'b00, i_temp_lsb_raw[2:0]};
    assign o_table_temp_res_ext    = enh_q[`ENH_TABLE_TEMP_RES_EXT_BIT];
    assign o_setpoint_unsigned_fmt = enh_q[`ENH_USF_BIT];
    assign o_duty_high_res_active  = hres;
    assign o_master_clock_sel      = pwm_cfg_q[`PWM_CLK_BIT];
    assign o_output_polarity       = pwm_cfg_q[`PWM_POL_BIT];
    assign o_fan_program_en        = prog_en;

    // ----------------------------------------
    // Duty path
    // ----------------------------------------
    // Table duty clipped to the active resolution
    assign lut_tgt = (i_lut_duty > duty_max) ? duty_max : i_lut_duty;

    fan_ramp_timer u_ramp (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_run     (smooth_en && is_22k5 && !prog_en &&
                    (duty_q != lut_tgt)),
        .i_rate    (enh_q[`ENH_RR_HI:`ENH_RR_LO]),
        .o_tick    (tick)
    );

    always @* begin
        duty_d = duty_q;
        if (prog_en) begin
            if (wr_duty) begin
                duty_d = i_reg_wdata & duty_max;
            end
        end else if (!smooth_en || !is_22k5) begin
            duty_d = lut_tgt;
        end else if (tick) begin
            if (duty_q < lut_tgt) begin
                duty_d = duty_q + 8'd1;
            end else begin
                duty_d = duty_q - 8'd1;
            end
        end
    end

    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            duty_q <= `RST_DUTY;
        end else begin
            duty_q <= duty_d;
        end
    end

    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_duty <= 8'h00;
        end else if (i_crit_event) begin
            o_duty <= i_crit_duty;
        end else if (i_spinup) begin
            o_duty <= i_spin_duty;
        end else begin
            o_duty <= duty_d;
        end
    end
endmodule // fan_enh_cfg

// ==== fan_enh_cfg_checker.sv ====
`timescale 1ns/1ps
module fan_enh_cfg_checker (
    input wire logic       i_clk_sys,
    input wire logic       i_nrst,
    input wire logic       i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       i_filter_active,
    input wire logic [7:0] o_temp_lsb,
    input wire logic       i_spinup,
    input wire logic       i_crit_event,
    input wire logic [7:0] i_crit_duty,
    input wire logic       o_table_temp_res_ext,
    input wire logic       o_duty_high_res_active,
    input wire logic       o_master_clock_sel,
    input wire logic       o_fan_program_en,
    input wire logic [7:0] o_duty
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    sequence s_wr45; i_reg_wr && i_reg_addr == 8'h45; endsequence
    property p_rsvd; i_reg_addr == 8'h45 |-> !o_reg_rdata[7]; endproperty
    a_rsvd: assert property (p_rsvd) else $error("bit 7 set");
    property p_filt; !i_filter_active |-> o_temp_lsb[4:3] == 2'b00; endproperty
    a_filt: assert property (p_filt) else $error("fine bits");
    property p_res;
        s_wr45 |=> o_table_temp_res_ext == $past(i_reg_wdata[5]);
    endproperty
    a_res: assert property (p_res) else $error("table res");
    property p_hres;
        o_duty_high_res_active |-> !o_master_clock_sel;
    endproperty
    a_hres: assert property (p_hres) else $error("high res");
    property p_lock;
        s_wr45 ##0 !o_fan_program_en ##1 i_reg_addr == 8'h45
            |-> o_reg_rdata[2:0] == $past(o_reg_rdata[2:0]);
    endproperty
    a_lock: assert property (p_lock) else $error("smooth bits moved");
    property p_keep;
        s_wr45 ##1 i_reg_addr == 8'h45
            |-> o_reg_rdata[6:3] == $past(i_reg_wdata[6:3]);
    endproperty
    a_keep: assert property (p_keep) else $error("upper bits");
    property p_crit; i_crit_event |=> o_duty == $past(i_crit_duty); endproperty
    a_crit: assert property (p_crit) else $error("crit duty");
    property p_direct;
        i_reg_wr && i_reg_addr == 8'h4c && o_fan_program_en && !i_spinup
            && !i_crit_event |=> o_duty == ($past(i_reg_wdata) &
            ($past(o_duty_high_res_active) ? 8'hff : 8'h3f));
    endproperty
    a_direct: assert property (p_direct) else $error("direct duty");
endmodule // fan_enh_cfg_checker

bind fan_enh_cfg fan_enh_cfg_checker chk (.*);

// ==== fan_host_model.sv ====
`timescale 1ns/1ps
module fan_host_model (
    input  wire logic       i_clk_sys,
    input  wire logic [7:0] i_reg_rdata,
    output logic            o_reg_wr,
    output logic [7:0]      o_reg_addr,
    output logic [7:0]      o_reg_wdata
);
    // ----------------------------------------
    // Register access
    // ----------------------------------------
    initial begin
        o_reg_wr = 1'b0;
        o_reg_addr = 8'h45;
        o_reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        #1 {o_reg_wr, o_reg_addr, o_reg_wdata} = {1'b1, a, d};
        @(posedge i_clk_sys);
        // Data line released: show garbage, not the old byte
        #1 {o_reg_wr, o_reg_wdata} = {1'b0, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        #1 o_reg_addr = a;
        #1 d = i_reg_rdata;
    endtask
    task automatic setup(input logic [7:0] e, input logic [7:0] d);
        // ready flag, beta and spin-up sit outside this block
        wr(8'h4a, 8'h20);
        wr(8'h4d, 8'h08);
        wr(8'h45, e);
        // direct duty as the single source
        wr(8'h4c, d);
    endtask
    // hand over to the table; later writes in any order
    task automatic to_table(input logic [7:0] v);
        wr(8'h4a, v);
    endtask
endmodule // fan_host_model

// ==== fan_enh_cfg_test.sv ====
`timescale 1ns/1ps
module fan_enh_cfg_test;
    logic        i_clk_sys, i_nrst, i_reg_wr, i_filter_active, i_spinup;
    logic        i_crit_event, o_table_temp_res_ext, o_setpoint_unsigned_fmt;
    logic        o_duty_high_res_active, o_master_clock_sel;
    logic        o_output_polarity, o_fan_program_en;
    logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, i_temp_lsb_raw, rd;
    logic [7:0]  o_temp_lsb, i_lut_duty, i_crit_duty, i_spin_duty, o_duty;
    logic [31:0] lf = 32'he05937be;
    logic [15:0] rst_tab [5] = '{16'h4500, 16'h4a20, 16'h4d17, 16'h4c00,
                                 16'h4600};
    integer      errors = 0, n_tests = 0, enh = 0, i;

    fan_enh_cfg dut (.*);
    fan_host_model host (.i_clk_sys(i_clk_sys), .i_reg_rdata(o_reg_rdata),
        .o_reg_wr(i_reg_wr), .o_reg_addr(i_reg_addr),
        .o_reg_wdata(i_reg_wdata));

    // ----------------------------------------
    // Checking and run control
    // ----------------------------------------
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        #200000;
        errors++;
        give_verdict;
    end
    initial begin
        {i_nrst, i_filter_active, i_spinup, i_crit_event} = 4'h0;
        {i_temp_lsb_raw, i_lut_duty, i_crit_duty, i_spin_duty} = 32'h0;
        repeat (5) @(posedge i_clk_sys);
        #1 i_nrst = 1'b1;
        for (i = 0; i < 5; i++) begin
            host.rd(rst_tab[i][15:8], rd);
            cmp(rd, rst_tab[i][7:0]);
        end
        // Prog toggles so locked and open writes of 0x45 interleave
        for (i = 0; i < 24; i++) begin
            lf = nxt(lf);
            host.wr(8'h4a, {2'b00, i[0], 5'h00});
            host.wr(8'h45, lf[7:0]);
            enh = i[0] ? lf[6:0] : {lf[6:3], enh[2:0]};
            host.rd(8'h45, rd);
            cmp(rd, enh[7:0]);
            cmp(o_table_temp_res_ext, enh[5]);
            cmp(o_setpoint_unsigned_fmt, enh[3]);
            {i_filter_active, i_temp_lsb_raw} = lf[16:8];
            #1;
            cmp(o_temp_lsb,
                lf[15:8] & (enh[6] & lf[16] ? 8'hff : 8'he7));
        end
        host.setup(8'h11, 8'ha5);
        cmp(o_duty_high_res_active, 1'b1);
        cmp(o_duty, 8'ha5);
        host.to_table(8'h00);
        repeat (20) @(posedge i_clk_sys);
        // Smoothing holds the duty until the first ramp tick
        #1 cmp(o_duty, 8'ha5);
        {i_spinup, i_spin_duty} = 9'h133;
        @(posedge i_clk_sys);
        #1 cmp(o_duty, 8'h33);
        {i_crit_event, i_crit_duty} = 9'h1c0;
        @(posedge i_clk_sys);
        #1 cmp(o_duty, 8'hc0);
        {i_spinup, i_crit_event, i_lut_duty} = 10'h02a;
        host.to_table(8'h08);
        #1 cmp(o_duty_high_res_active, 1'b0);
        cmp(o_master_clock_sel, 1'b1);
        @(posedge i_clk_sys);
        #1 cmp(o_duty, 8'h2a);
        give_verdict;
    end
endmodule // fan_enh_cfg_test
